// >>> hdl/hss_pkg.sv
/*
  Shared constants and types of the home search status and error block.
  Assumes a 32-bit APB slave decode on byte addresses and one system clock.
*/
// ***********************************************************************
// Register map, command codes, fields and state codes
// ***********************************************************************
package hss_pkg;
  // Byte addresses of the register words
  localparam logic [7:0]  ADDR_CMD     = 8'h00;  // Command code, write only
  localparam logic [7:0]  ADDR_MODE    = 8'h04;  // Step enables and directions
  localparam logic [7:0]  ADDR_OFFSET  = 8'h08;  // Step 4 offset pulse count
  localparam logic [7:0]  ADDR_SPEED   = 8'h0c;  // Pulse periods, high and low speed
  localparam logic [7:0]  ADDR_MAIN    = 8'h10;  // Main status
  localparam logic [7:0]  ADDR_STAT1   = 8'h14;  // Axis status one
  localparam logic [7:0]  ADDR_STAT2   = 8'h18;  // Axis status two
  // Command codes
  localparam logic [7:0]  CMD_HOME     = 8'h62;  // Start home search
  localparam logic [7:0]  CMD_TCLR     = 8'h25;  // Termination status clear
  localparam logic [7:0]  CMD_DSTOP    = 8'h26;  // Decelerating stop
  localparam logic [7:0]  CMD_ISTOP    = 8'h27;  // Instant stop
  // Mode register fields
  localparam int          MODE_S1_EN   = 0;
  localparam int          MODE_S1_DIR  = 1;
  localparam int          MODE_S2_EN   = 2;
  localparam int          MODE_S2_DIR  = 3;
  localparam int          MODE_S3_EN   = 4;
  localparam int          MODE_S3_DIR  = 5;
  localparam int          MODE_S4_EN   = 6;
  localparam int          MODE_S4_DIR  = 7;
  localparam int          MODE_LIM_DEC = 8;      // Limit stop in steps 3 and 4: 0 instant, 1 decelerate
  // Axis status two fields
  localparam int          S2_LIM_PLUS  = 2;
  localparam int          S2_LIM_MINUS = 3;
  localparam int          S2_ALARM     = 4;
  localparam int          S2_EMG       = 5;
  localparam int          S2_ZPHASE    = 7;
  localparam int          S2_CODE_LSB  = 8;
  localparam int          S2_CODE_MSB  = 12;
  // Axis status one field: termination causes start here
  localparam int          S1_TERM_LSB  = 12;     // Plus, minus, alarm, emergency
  // Main status fields
  localparam int          MAIN_DRV     = 0;
  localparam int          MAIN_ERR     = 4;
  localparam int          MAIN_BUSY    = 8;
  // Synchronised input positions
  localparam int          IN_NEAR      = 0;
  localparam int          IN_HOME      = 1;
  localparam int          IN_INDEX     = 2;
  localparam int          IN_PLUS      = 3;
  localparam int          IN_MINUS     = 4;
  localparam int          IN_EMG       = 5;
  localparam int          IN_ALARM     = 6;
  // Execution state codes
  localparam logic [4:0]  CODE_IDLE    = 5'h00;
  localparam logic [4:0]  CODE_S1      = 5'h03;
  localparam logic [4:0]  CODE_REV_ON  = 5'h08;
  localparam logic [4:0]  CODE_REV_OFF = 5'h0c;
  localparam logic [4:0]  CODE_FWD     = 5'h0f;
  localparam logic [4:0]  CODE_S3      = 5'h14;
  localparam logic [4:0]  CODE_S4      = 5'h19;
  // Reset values and timing
  localparam logic [8:0]  MODE_RST     = 9'h000;
  localparam logic [15:0] OFFSET_RST   = 16'h0000;
  localparam logic [31:0] SPEED_RST    = 32'h0010_0004;
  localparam logic [15:0] DECEL_TICKS  = 16'h0008;  // Pulse periods of a decelerating stop
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_S1, ST_REV_ON, ST_REV_OFF, ST_FWD, ST_S3, ST_S4, ST_DECEL
  } hss_st_t;
endpackage

// >>> hdl/hss_home_search.sv
/*
  Home search sequencer of one axis with its status and error reporting,
  reached over APB. Assumes sensor and limit pins are active high after
  logic setting elsewhere, and that the drive follows pulse_out/dir_out.
*/
module hss_home_search
  import hss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        near_home_input,
  input  wire logic        home_sensor_input,
  input  wire logic        encoder_index_input,
  input  wire logic        plus_overrun_limit,
  input  wire logic        minus_overrun_limit,
  input  wire logic        emergency_stop_input,
  input  wire logic        servo_alarm_input,
  output logic             pulse_out,
  output logic             dir_out,
  output logic             busy_out
);
  // ***********************************************************************
  // Input synchronisers
  // ***********************************************************************
  logic [6:0]  raw_in;     // Pins, unsynchronised
  logic [6:0]  meta_q;     // First stage, read only by second stage
  logic [6:0]  sy_q;       // Safe to use
  assign raw_in = {servo_alarm_input, emergency_stop_input, minus_overrun_limit,
                   plus_overrun_limit, encoder_index_input, home_sensor_input,
                   near_home_input};
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_sync
      // Two flops per pin against metastability
      always_ff @(posedge clk)
      begin
        meta_q[gi] <= rst ? 1'b0 : raw_in[gi];
        sy_q[gi]   <= rst ? 1'b0 : meta_q[gi];
      end
    end
  endgenerate

  // ***********************************************************************
  // APB register access
  // ***********************************************************************
  logic        wr_acc;                 // Write access phase
  logic        cmd_wr;                 // Command word written
  logic [7:0]  cmd;                    // Command code
  logic        start_cmd, tclr_cmd, dstop_cmd, istop_cmd;
  logic [8:0]  mode_q,   mode_d;       // Step enables, directions
  logic [15:0] offset_q, offset_d;     // Offset pulse count
  logic [31:0] speed_q,  speed_d;      // Low period 31:16, high 15:0
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pslverr_q, pslverr_d;
  logic [31:0] main_stat, stat1, stat2;
  logic        mapped;
  assign wr_acc    = psel && penable && pwrite;
  assign cmd_wr    = wr_acc && (paddr == ADDR_CMD);
  assign cmd       = pwdata[7:0];
  assign start_cmd = cmd_wr && (cmd == CMD_HOME);
  assign tclr_cmd  = cmd_wr && (cmd == CMD_TCLR);
  assign dstop_cmd = cmd_wr && (cmd == CMD_DSTOP);
  assign istop_cmd = cmd_wr && (cmd == CMD_ISTOP);
  assign mapped = (paddr == ADDR_CMD) || (paddr == ADDR_MODE) || (paddr == ADDR_OFFSET) ||
                  (paddr == ADDR_SPEED) || (paddr == ADDR_MAIN) ||
                  (paddr == ADDR_STAT1) || (paddr == ADDR_STAT2);

  // Register writes and read mux; read data latched in the setup cycle
  always_comb
  begin
    mode_d    = mode_q;
    offset_d  = offset_q;
    speed_d   = speed_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (wr_acc && paddr == ADDR_MODE)
      mode_d = pwdata[8:0];
    if (wr_acc && paddr == ADDR_OFFSET)
      offset_d = pwdata[15:0];
    if (wr_acc && paddr == ADDR_SPEED)
      speed_d = pwdata;
    if (psel && !penable)
    begin
      pslverr_d = !mapped;
      case (paddr)
        ADDR_MODE:   prdata_d = {23'h000000, mode_q};
        ADDR_OFFSET: prdata_d = {16'h0000, offset_q};
        ADDR_SPEED:  prdata_d = speed_q;
        ADDR_MAIN:   prdata_d = main_stat;
        ADDR_STAT1:  prdata_d = stat1;
        ADDR_STAT2:  prdata_d = stat2;
        default:     prdata_d = 32'h0000_0000;          // Command word reads zero
      endcase
    end
  end

  // Bus registers; pready is high from the first cycle after reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q    <= MODE_RST;
      offset_q  <= OFFSET_RST;
      speed_q   <= SPEED_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      mode_q    <= mode_d;
      offset_q  <= offset_d;
      speed_q   <= speed_d;
      prdata_q  <= prdata_d;
      pready_q  <= 1'b1;
      pslverr_q <= pslverr_d;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ***********************************************************************
  // Home search sequencer
  // ***********************************************************************
  hss_st_t     st_q, st_d;             // Current step and sub-state
  logic        first_q, first_d;       // First cycle of a step: entry checks
  logic [7:0]  err2_q, err2_d;         // Status two error byte
  logic [3:0]  term1_q, term1_d;       // Status one termination causes
  logic [15:0] off_q, off_d;           // Offset pulses issued
  logic [15:0] dec_q, dec_d;           // Deceleration periods left
  logic [15:0] div_q, div_d;           // Pulse period divider
  logic        pulse_q, pulse_d;
  logic        dir_q, dir_d;
  logic        busy_q;
  logic [3:0]  en, sdir;               // Step enables, directions (1 = minus)
  logic        dir, lim_dir, moving, tick, quiet;
  logic [15:0] period;
  logic [4:0]  exec_code;
  logic [7:0]  err2_set;
  logic [3:0]  term1_set;
  assign en   = {mode_q[MODE_S4_EN], mode_q[MODE_S3_EN], mode_q[MODE_S2_EN], mode_q[MODE_S1_EN]};
  assign sdir = {mode_q[MODE_S4_DIR], mode_q[MODE_S3_DIR], mode_q[MODE_S2_DIR],
                 mode_q[MODE_S1_DIR]};
  assign quiet = !sy_q[IN_EMG] && !sy_q[IN_ALARM] && !dstop_cmd && !istop_cmd;

  // First enabled step at or after index k, else idle
  function automatic hss_st_t step_from(input int k, input logic [3:0] e);
    hss_st_t r;
    r = ST_IDLE;
    for (int i = 3; i >= 0; i--)
      if (e[i] && i >= k)
        case (i)
          0:       r = ST_S1;
          1:       r = ST_FWD;
          2:       r = ST_S3;
          default: r = ST_S4;
        endcase
    return r;
  endfunction

  // Direction and speed of the current step
  always_comb
  begin
    case (st_q)
      ST_S1:              dir = sdir[0];
      ST_FWD:             dir = sdir[1];
      ST_REV_ON, ST_REV_OFF: dir = !sdir[1];     // Irregular reverse move
      ST_S3:              dir = sdir[2];
      ST_S4:              dir = sdir[3];
      default:            dir = dir_q;
    endcase
    period = (st_q == ST_S1 || st_q == ST_S4) ? speed_q[15:0] : speed_q[31:16];
  end
  assign lim_dir = dir ? sy_q[IN_MINUS] : sy_q[IN_PLUS];
  assign moving  = !first_q && (st_q != ST_IDLE) && (st_q != ST_DECEL);
  assign tick    = (st_q != ST_IDLE) && (div_q + 16'h0001 >= period);

  // Execution state code from the sub-state
  always_comb
  begin
    case (st_q)
      ST_S1:      exec_code = CODE_S1;
      ST_REV_ON:  exec_code = CODE_REV_ON;
      ST_REV_OFF: exec_code = CODE_REV_OFF;
      ST_FWD:     exec_code = CODE_FWD;
      ST_S3:      exec_code = CODE_S3;
      ST_S4:      exec_code = CODE_S4;
      default:    exec_code = CODE_IDLE;
    endcase
  end

  // Next step, error flags and pulse generation
  always_comb
  begin
    st_d      = st_q;
    err2_set  = 8'h00;
    term1_set = 4'h0;
    off_d     = off_q;
    dec_d     = dec_q;
    div_d     = tick ? 16'h0000 : div_q + 16'h0001;
    // Never step toward an active limit
    pulse_d   = tick && moving && !lim_dir;
    dir_d     = dir;
    if (st_q == ST_IDLE)
    begin
      div_d = 16'h0000;
      if (start_cmd)
        st_d = step_from(0, en);
    end
    else if (sy_q[IN_EMG])
    begin
      // Emergency stop: no more pulses, remaining steps dropped
      st_d = ST_IDLE;
      pulse_d = 1'b0;
      err2_set[S2_EMG] = 1'b1;
      term1_set[3] = 1'b1;
    end
    else if (sy_q[IN_ALARM])
    begin
      st_d = ST_IDLE;
      pulse_d = 1'b0;
      err2_set[S2_ALARM] = 1'b1;
      term1_set[2] = 1'b1;
    end
    else if (istop_cmd || dstop_cmd)
    begin
      // Stop commands end the whole sequence
      st_d = (dstop_cmd && st_q != ST_DECEL) ? ST_DECEL : ST_IDLE;
      dec_d = DECEL_TICKS;
      pulse_d = 1'b0;
    end
    else
      case (st_q)
        ST_S1:
          if (sy_q[IN_NEAR])
            st_d = step_from(1, en);
          else if (lim_dir)
            st_d = en[1] ? ST_REV_ON : step_from(2, en);
        ST_FWD:
          if (first_q && sy_q[IN_HOME])
            st_d = ST_REV_OFF;                           // Start on home: back off first
          else if (sy_q[IN_HOME])
            st_d = step_from(2, en);
          else if (lim_dir)
            st_d = ST_REV_ON;
        ST_REV_ON, ST_REV_OFF:
          if (lim_dir)
          begin
            // Limits hit both ways: give up with this side's error
            st_d = ST_IDLE;
            err2_set[dir ? S2_LIM_MINUS : S2_LIM_PLUS] = 1'b1;
          end
          else if (st_q == ST_REV_ON && sy_q[IN_HOME])
            st_d = ST_REV_OFF;
          else if (st_q == ST_REV_OFF && !sy_q[IN_HOME])
            st_d = ST_FWD;
        ST_S3:
          if (first_q && sy_q[IN_INDEX])
          begin
            st_d = ST_IDLE;
            err2_set[S2_ZPHASE] = 1'b1;
          end
          else if (lim_dir)
          begin
            st_d = mode_q[MODE_LIM_DEC] ? ST_DECEL : ST_IDLE;
            dec_d = DECEL_TICKS;
            err2_set[dir ? S2_LIM_MINUS : S2_LIM_PLUS] = 1'b1;
            term1_set[dir ? 1 : 0] = 1'b1;
          end
          else if (!first_q && sy_q[IN_INDEX])
            st_d = step_from(3, en);
        ST_S4:
          if (lim_dir)
          begin
            st_d = mode_q[MODE_LIM_DEC] ? ST_DECEL : ST_IDLE;
            dec_d = DECEL_TICKS;
            err2_set[dir ? S2_LIM_MINUS : S2_LIM_PLUS] = 1'b1;
            term1_set[dir ? 1 : 0] = 1'b1;
          end
          else if (off_q == offset_q)
          begin
            st_d = ST_IDLE;
            pulse_d = 1'b0;
          end
          else if (pulse_d)
            off_d = off_q + 16'h0001;
        ST_DECEL:
          // Ramp-down time; moving is low in this state, so no pulses
          if (dec_q == 16'h0000)
            st_d = ST_IDLE;
          else if (tick)
            dec_d = dec_q - 16'h0001;
        default:
          st_d = ST_IDLE;
      endcase
    first_d = (st_d != st_q) && (st_d != ST_IDLE) && (st_d != ST_DECEL);
    if (st_d == ST_S4 && st_q != ST_S4)
      off_d = 16'h0000;
    // Set wins over clear; start clears all, clear command only its part
    err2_d  = (err2_q & (start_cmd ? 8'h00 : (tclr_cmd ? 8'h7f : 8'hff))) | err2_set;
    term1_d = (term1_q & ((start_cmd || tclr_cmd) ? 4'h0 : 4'hf)) | term1_set;
  end

  // Sequencer registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q    <= ST_IDLE;
      first_q <= 1'b0;
      err2_q  <= 8'h00;
      term1_q <= 4'h0;
      off_q   <= 16'h0000;
      dec_q   <= 16'h0000;
      div_q   <= 16'h0000;
      pulse_q <= 1'b0;
      dir_q   <= 1'b0;
      busy_q  <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      first_q <= first_d;
      err2_q  <= err2_d;
      term1_q <= term1_d;
      off_q   <= off_d;
      dec_q   <= dec_d;
      div_q   <= div_d;
      pulse_q <= pulse_d;
      dir_q   <= dir_d;
      busy_q  <= (st_d != ST_IDLE);
    end
  end
  assign pulse_out = pulse_q;
  assign dir_out   = dir_q;
  assign busy_out  = busy_q;

  // Status words; the main error also shows a live search-side limit
  assign stat2 = {19'h00000, exec_code, err2_q};
  assign stat1 = {16'h0000, term1_q, 12'h000};
  assign main_stat = {23'h000000, busy_q, 3'h0,
                      (|err2_q) || (moving && lim_dir), 3'h0, pulse_q};

  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_zphase_set: assert property (st_q == ST_S3 && first_q && sy_q[IN_INDEX] && quiet
    |=> err2_q[S2_ZPHASE] && st_q == ST_IDLE) else $error("index error not flagged");
  a_zphase_clear: assert property (tclr_cmd && !err2_set[S2_ZPHASE]
    |=> !err2_q[S2_ZPHASE]) else $error("index error not cleared");
  a_main_err: assert property (err2_q[S2_ZPHASE] |-> main_stat[MAIN_ERR])
    else $error("main error missing");
  a_status_read: assert property (psel && !penable && paddr == ADDR_STAT2
    |=> prdata[12:8] == $past(exec_code) && prdata[7:0] == $past(err2_q))
    else $error("status two layout wrong");
  a_alarm_stop: assert property (sy_q[IN_ALARM] && !sy_q[IN_EMG] && st_q != ST_IDLE
    |=> st_q == ST_IDLE && !pulse_out && err2_q[S2_ALARM] && term1_q[2])
    else $error("alarm stop wrong");
  a_emg_stop: assert property (sy_q[IN_EMG] && st_q != ST_IDLE
    |=> !pulse_out && err2_q[S2_EMG] && term1_q[3] && !busy_out)
    else $error("emergency stop wrong");
  a_limit_block: assert property (moving && lim_dir |=> !pulse_out)
    else $error("pulse toward active limit");
  a_s3_limit: assert property (st_q == ST_S3 && !first_q && lim_dir && quiet
    |=> (err2_q[S2_LIM_PLUS] || err2_q[S2_LIM_MINUS]) && st_q != ST_S4)
    else $error("step 3 limit not handled");
  a_s4_limit: assert property (st_q == ST_S4 && lim_dir && quiet
    |=> st_q inside {ST_IDLE, ST_DECEL} && |term1_q[1:0])
    else $error("step 4 limit not handled");
  a_near_skip: assert property (st_q == ST_S1 && sy_q[IN_NEAR] && quiet
    |=> exec_code != CODE_S1) else $error("step 1 not skipped");
  a_s1_limit: assert property (st_q == ST_S1 && !first_q && !sy_q[IN_NEAR] && lim_dir
    && quiet && en[1] |=> exec_code == CODE_REV_ON) else $error("no irregular step 2");
  a_rev_fail: assert property (st_q == ST_REV_ON && lim_dir && quiet
    |=> st_q == ST_IDLE ##1 exec_code == CODE_IDLE) else $error("double limit not ended");
  a_back_off: assert property (st_q == ST_REV_ON && !lim_dir && sy_q[IN_HOME] && quiet
    |=> exec_code == CODE_REV_OFF) else $error("code 12 missing");
  a_idle_code: assert property ($fell(busy_out) |-> exec_code == CODE_IDLE)
    else $error("state code not idle");
  a_istop_end: assert property (istop_cmd && st_q != ST_IDLE
    |=> st_q == ST_IDLE [*2]) else $error("instant stop ignored");
  a_start_step: assert property (st_q == ST_IDLE && start_cmd && en[0]
    |=> exec_code == CODE_S1 && busy_out) else $error("home start failed");
  c_full_run: cover property (st_q == ST_S4 ##1 st_q == ST_IDLE);
  c_zphase_err: cover property (err2_set[S2_ZPHASE]);
  c_irregular: cover property (st_q == ST_REV_ON ##[1:1000] st_q == ST_FWD);
  c_decel: cover property (st_q == ST_DECEL ##1 st_q == ST_IDLE);
endmodule

// >>> verification/hss_axis_model.sv
/*
  Far-side model: one axis whose position follows pulse_out and dir_out,
  with near-home, home, index and both limits placed along its travel.
  Assumes all sensors active high and that reset starts the axis at 40.
*/
module hss_axis_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pulse_out,
  input  wire logic dir_out,
  output logic      axis_near,
  output logic      axis_home,
  output logic      axis_index,
  output logic      axis_plus,
  output logic      axis_minus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************************************
  // Position and sensor map
  // ***********************************************************
  int pos_q;  // Axis position in pulses
  // One step per drive pulse, dir 1 moves minus
  always_ff @(posedge clk)
  begin
    if (rst)
      pos_q <= 40;
    else if (pulse_out)
      pos_q <= dir_out ? pos_q - 1 : pos_q + 1;
  end
  assign axis_near  = pos_q <= 20;                 // Near zone, far below start
  assign axis_home  = (pos_q >= 6) && (pos_q <= 10);
  // Four pulses wide, so slow search holds it past the input delay
  assign axis_index = (pos_q >= 14) && (pos_q <= 17);
  assign axis_plus  = pos_q >= 80;                 // Ends of travel
  assign axis_minus = pos_q <= -30;
endmodule

// >>> verification/test_home_search_status_errors.sv
/*
  Self-checking bench of the home search block: bus cases, table of sensor
  faults, then clear and stop cases. Assumes the axis model beside it.
*/
module test_home_search_status_errors import hss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ***********************************************************
  // Signals and table
  // ***********************************************************
  logic clk, rst, psel, penable, pwrite, pready, pslverr, se;
  logic pulse_out, dir_out, busy_out, an, ah, ai, ap, am;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seen;
  logic [6:0]  on_q, off_q, sens;  // Stuck-on and stuck-off faults
  int n_mismatch, n_tests, cyc, npulse;
  typedef struct {logic [8:0] m; logic [6:0] on, off; logic [15:0] s2, s1;
                  logic [31:0] cd; logic pz;} hss_row_t;
  // Mode, faults, status two, status one, codes seen, no pulses
  hss_row_t rows [11] = '{
    '{9'h05f, 7'h00, 7'h00, 16'h0000, 16'h0000, 32'h0210_8008, 1'b0},
    '{9'h05f, 7'h01, 7'h00, 16'h0000, 16'h0000, 32'h0, 1'b0},
    '{9'h05f, 7'h40, 7'h00, 16'h0010, 16'h4000, 32'h0, 1'b0},
    '{9'h05f, 7'h20, 7'h00, 16'h0020, 16'h8000, 32'h0, 1'b0},
    '{9'h05f, 7'h00, 7'h04, 16'h0004, 16'h1000, 32'h0, 1'b0},
    '{9'h15f, 7'h00, 7'h04, 16'h0004, 16'h1000, 32'h0, 1'b0},
    '{9'h05f, 7'h00, 7'h02, 16'h0004, 16'h0000, 32'h0, 1'b0},
    '{9'h00c, 7'h02, 7'h00, 16'h0004, 16'h0000, 32'h1000, 1'b0},
    '{9'h040, 7'h08, 7'h00, 16'h0004, 16'h1000, 32'h0, 1'b1},
    '{9'h05f, 7'h00, 7'h01, 16'h0000, 16'h0000, 32'h0210_9108, 1'b0},
    '{9'h05f, 7'h04, 7'h00, 16'h0080, 16'h0000, 32'h0, 1'b0}};
  assign sens = ({2'b00, am, ap, ai, ah, an} | on_q) & ~off_q;
  hss_home_search hss_home_search_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .near_home_input(sens[IN_NEAR]), .home_sensor_input(sens[IN_HOME]),
    .encoder_index_input(sens[IN_INDEX]), .plus_overrun_limit(sens[IN_PLUS]),
    .minus_overrun_limit(sens[IN_MINUS]), .emergency_stop_input(sens[IN_EMG]),
    .servo_alarm_input(sens[IN_ALARM]), .pulse_out(pulse_out),
    .dir_out(dir_out), .busy_out(busy_out));
  hss_axis_model hss_axis_model_i (.clk(clk), .rst(rst), .pulse_out(pulse_out),
    .dir_out(dir_out), .axis_near(an), .axis_home(ah), .axis_index(ai),
    .axis_plus(ap), .axis_minus(am));
  // ***********************************************************
  // Tasks
  // ***********************************************************
  // APB transfer, held until pready seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; se = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Fresh axis, faults set in reset; optional stop mid-search
  task run(input hss_row_t r, input logic [7:0] stp);
    int t;
    rst <= 1'b1; on_q <= r.on; off_q <= r.off;
    repeat (3) @(posedge clk);
    rst <= 1'b0; npulse = 0;
    apb(1'b1, ADDR_MODE, 32'(r.m));
    apb(1'b1, ADDR_OFFSET, 32'h5);
    apb(1'b1, ADDR_CMD, 32'(CMD_HOME));
    if (stp != 8'h00)
    begin
      repeat (40) @(posedge clk);
      apb(1'b1, ADDR_CMD, 32'(stp));
    end
    repeat (2) @(posedge clk);
    seen = 0; t = 0;
    // Poll the state code while the search runs
    while (busy_out === 1'b1 && t < 3000)
    begin
      apb(1'b0, ADDR_STAT2, 32'h0);
      seen |= 32'h1 << rd[12:8];
      t++;
    end
    chk("busy", 32'(busy_out), 32'h0);
    apb(1'b0, ADDR_STAT2, 32'h0);
  endtask
  // ***********************************************************
  // Clock, timeout, pulse count and main sequence
  // ***********************************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A hang counts as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (pulse_out === 1'b1)
      npulse++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      results;
    end
  end
  initial
  begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; on_q = 7'h00; off_q = 7'h00;
    repeat (20) @(posedge clk);
    chk("pready_rst", 32'(pready), 32'h0);
    rst <= 1'b0;
    apb(1'b0, ADDR_SPEED, 32'h0);
    chk("speed_rst", rd, SPEED_RST);
    // Low search speed kept slower than the high speed
    apb(1'b1, ADDR_SPEED, 32'h0010_0003);
    apb(1'b0, ADDR_SPEED, 32'h0);
    chk("speed_wr", rd, 32'h0010_0003);
    apb(1'b0, ADDR_MODE, 32'h0);
    chk("mode_rst", rd, 32'(MODE_RST));
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", {rd[30:0], se}, 32'h1);
    foreach (rows[i])
    begin
      run(rows[i], 8'h00);
      chk("stat2", rd, 32'(rows[i].s2));
      if (rows[i].cd != 0)
        chk("codes", seen & rows[i].cd, rows[i].cd);
      apb(1'b0, ADDR_STAT1, 32'h0);
      chk("stat1", rd & 32'hf000, 32'(rows[i].s1));
      apb(1'b0, ADDR_MAIN, 32'h0);
      chk("main_err", 32'(rd[MAIN_ERR]), 32'(|rows[i].s2[7:0]));
      if (rows[i].pz)
        chk("pulses", 32'(npulse), 32'h0);
    end
    // Last row left the index error standing
    apb(1'b1, ADDR_CMD, 32'(CMD_TCLR));
    apb(1'b0, ADDR_STAT2, 32'h0);
    chk("tclr", rd, 32'h0);
    // Both stops end the search before steps 3 and 4
    run(rows[0], CMD_DSTOP);
    chk("dstop", {rd[12:8], seen[25], seen[20]}, 7'h00);
    run(rows[0], CMD_ISTOP);
    chk("istop", {rd[12:8], seen[25], seen[20]}, 7'h00);
    results;
  end
endmodule
